// ---- hw/dual_adc_pkg.sv ----
// Package for the dual converter serial readout block.
// Assumes one system clock and a separate serial clock from the host.
package dual_adc_pkg;
	localparam int RESULT_BITS     = 12;
	localparam int LEAD_ZEROS      = 2;
	localparam int FRAME_SHORT     = 14;
	localparam int FRAME_SINGLE    = 16;
	localparam int FRAME_CHAINED   = 32;
	localparam int BIT_CNT_W       = 6;
	localparam logic [5:0] BIT_CNT_RESET = 6'h00;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [2:0]  CHAN_RESET   = 3'h0;

	// Converter sample request captured at frame start
	typedef struct packed {
		logic [2:0] channel_pair_select;
		logic       input_config_select;
		logic       range_double;
	} sample_cfg_t;

	// Pair of conversion results
	typedef struct packed {
		logic [11:0] first;
		logic [11:0] second;
	} result_pair_t;
endpackage : dual_adc_pkg

// ---- hw/sar_step.sv ----
// Successive-approximation engine clocked by the serial clock.
// Assumes the comparator decision arrives on the same serial clock.
`timescale 1ns/1ns
module sar_step
	import dual_adc_pkg::*;
(
	input  wire logic                   sclk_i,
	input  wire logic                   start_i,
	input  wire logic                   cmp_i,
	output logic [RESULT_BITS-1:0]      trial_o,
	output logic [RESULT_BITS-1:0]      result_o
);
	logic [RESULT_BITS-1:0] bit_r;
	logic [RESULT_BITS-1:0] acc_r;

	// One decision per serial clock, MSB first; start reloads the trial
	always_ff @(posedge sclk_i) begin
		if (start_i) begin
			bit_r <= {1'b1, {(RESULT_BITS-1){1'b0}}};
			acc_r <= RESULT_RESET;
		end else if (bit_r != RESULT_RESET) begin
			if (cmp_i) begin
				acc_r <= acc_r | bit_r;
			end
			bit_r <= bit_r >> 1;
		end
	end

	// Result register updated when the last bit is decided
	always_ff @(posedge sclk_i) begin
		if (start_i) begin
			result_o <= RESULT_RESET;
		end else if (bit_r == 12'h001) begin
			result_o <= cmp_i ? (acc_r | bit_r) : acc_r;
		end
	end

	assign trial_o = acc_r | bit_r;
endmodule : sar_step

// ---- hw/dual_adc_serial_readout.sv ----
// Serial readout of a dual simultaneous-sampling 12-bit converter.
// Assumes the host drives frame_n and sclk; sclk may stop outside frames.
// Summary of operation
// - Each data output changes to its next bit on every falling serial clock edge.
// - Both results come out together, one per pin, from one shared sample.
// - A frame starts with two zero bits, then the 12 result bits.
// - Result bits leave most significant first, least significant last.
// - With 16 clocks the frame ends with two more zero bits.
// - A further 16 clocks chain the other converter's result on the same pin.
// - Frame select falling edge starts the data frame; the first rising serial clock after it starts both conversions.
// - Serial clock paces the successive approximation as well as the shifting.
// - Range select is taken at frame start: low single span, high double.
`timescale 1ns/1ns
module dual_adc_serial_readout
	import dual_adc_pkg::*;
(
	input  wire logic                   clock_i,
	input  wire logic                   reset_i,
	input  wire logic                   sclk_i,
	input  wire logic                   frame_n_i,
	input  wire logic [2:0]             channel_pair_select_i,
	input  wire logic                   input_config_select_i,
	input  wire logic                   range_select_i,
	input  wire logic                   cmp_first_i,
	input  wire logic                   cmp_second_i,
	output logic [RESULT_BITS-1:0]      trial_first_o,
	output logic [RESULT_BITS-1:0]      trial_second_o,
	output logic                        result_out_first_o,
	output logic                        result_out_first_oe_o,
	output logic                        result_out_second_o,
	output logic                        result_out_second_oe_o,
	output sample_cfg_t                 sample_cfg_o,
	output logic                        sample_pulse_o,
	output result_pair_t                last_result_o,
	output logic                        frame_active_o
);
	// Link domain state (serial clock)
	logic [BIT_CNT_W-1:0] bit_cnt_r;
	logic                 frame_seen_r;
	sample_cfg_t          cfg_r;
	logic [RESULT_BITS-1:0] res_first;
	logic [RESULT_BITS-1:0] res_second;
	logic                 dout_first_r;
	logic                 dout_second_r;
	logic                 start_conv;

	// Frame start is the first rising sclk after frame select drops
	assign start_conv = !frame_n_i && !frame_seen_r;

	// Frame tracking and serial bit counter; cleared when frame ends
	always_ff @(posedge sclk_i or posedge frame_n_i) begin
		if (frame_n_i) begin
			frame_seen_r <= 1'b0;
			bit_cnt_r    <= BIT_CNT_RESET;
		end else begin
			frame_seen_r <= 1'b1;
			if (bit_cnt_r != 6'h3F) begin
				bit_cnt_r <= bit_cnt_r + 6'h01;
			end
		end
	end

	// Capture channel, input mode and range at frame start
	always_ff @(posedge sclk_i) begin
		if (start_conv) begin
			cfg_r.channel_pair_select <= channel_pair_select_i;
			cfg_r.input_config_select <= input_config_select_i;
			cfg_r.range_double        <= range_select_i;
		end
	end

	// Both converters start on the same edge from one sample instant
	sar_step u_sar_first (
		.sclk_i   (sclk_i),
		.start_i  (start_conv),
		.cmp_i    (cmp_first_i),
		.trial_o  (trial_first_o),
		.result_o (res_first)
	);

	sar_step u_sar_second (
		.sclk_i   (sclk_i),
		.start_i  (start_conv),
		.cmp_i    (cmp_second_i),
		.trial_o  (trial_second_o),
		.result_o (res_second)
	);

	// Bit select: position within the frame picks zero or a result bit
	function automatic logic pick_bit(input logic [BIT_CNT_W-1:0] pos,
		input logic [RESULT_BITS-1:0] own,
		input logic [RESULT_BITS-1:0] other,
		input logic [RESULT_BITS-1:0] trial);
		logic [4:0] idx;
		logic       val;
		idx = 5'h00;
		val = 1'b0;
		if (pos >= 6'(LEAD_ZEROS) && pos < 6'(LEAD_ZEROS + RESULT_BITS)) begin
			idx = 5'(LEAD_ZEROS + RESULT_BITS - 1) - pos[4:0];
			val = trial[idx[3:0]]; // Bits become known as the approximation walks
		end else if (pos >= 6'(FRAME_SINGLE + LEAD_ZEROS)
			&& pos < 6'(FRAME_SINGLE + LEAD_ZEROS + RESULT_BITS)) begin
			idx = 5'(FRAME_SINGLE + LEAD_ZEROS + RESULT_BITS - 1 - FRAME_SINGLE)
				- (pos[4:0] - 5'(FRAME_SINGLE));
			val = other[idx[3:0]];
		end
		if (own == RESULT_RESET && pos == 6'h3F) begin
			val = 1'b0;
		end
		return val;
	endfunction : pick_bit

	// Outputs change on the falling edge; counter holds bits already shifted
	always_ff @(negedge sclk_i or posedge frame_n_i) begin
		if (frame_n_i) begin
			dout_first_r  <= 1'b0;
			dout_second_r <= 1'b0;
		end else begin
			dout_first_r  <= pick_bit(bit_cnt_r, res_first, res_second,
				trial_first_o);
			dout_second_r <= pick_bit(bit_cnt_r, res_second, res_first,
				trial_second_o);
		end
	end

	// Pins driven only inside a frame
	assign result_out_first_o     = dout_first_r;
	assign result_out_second_o    = dout_second_r;
	assign result_out_first_oe_o  = !frame_n_i;
	assign result_out_second_oe_o = !frame_n_i;

	// System domain: two-stage synchroniser on the frame select level
	logic       frame_s1_r, frame_s2_r;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			frame_s1_r <= 1'b1;
			frame_s2_r <= 1'b1;
		end else begin
			frame_s1_r <= frame_n_i;
			frame_s2_r <= frame_s1_r;
		end
	end

	// Hand-over when the synchronised select rises; the serial clock stands
	// still then, so link-side config and results are stable to read here.
	// Limitation: the host must not restart a frame within three system clocks.
	logic frame_s3_r;
	logic frame_close;
	assign frame_close = frame_s2_r && !frame_s3_r;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sample_pulse_o <= 1'b0;
			sample_cfg_o   <= '0;
			last_result_o  <= '0;
			frame_s3_r     <= 1'b1;
			frame_active_o <= 1'b0;
		end else begin
			frame_s3_r     <= frame_s2_r;
			frame_active_o <= !frame_s2_r;
			sample_pulse_o <= frame_close;
			if (frame_close) begin
				sample_cfg_o         <= cfg_r;
				last_result_o.first  <= res_first;
				last_result_o.second <= res_second;
			end
		end
	end
endmodule : dual_adc_serial_readout

// ---- bench/dual_adc_serial_readout_monitor.sv ----
// Checker for the serial readout ports of the dual converter.
// Assumes binding to the top module; frame select high clears the edge count.
`timescale 1ns/1ns
module dual_adc_serial_readout_monitor (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic frame_n_i,
	input wire logic result_out_first_o,
	input wire logic result_out_first_oe_o,
	input wire logic result_out_second_o,
	input wire logic result_out_second_oe_o,
	input wire logic sample_pulse_o,
	input wire logic frame_active_o
);
	logic [5:0] fall_cnt_r;
	// Falling serial edges seen in the current frame
	always_ff @(negedge sclk_i or posedge frame_n_i) begin
		if (frame_n_i) fall_cnt_r <= 6'h00;
		else if (fall_cnt_r != 6'h3F) fall_cnt_r <= fall_cnt_r + 6'h01;
	end
	oe_first_a: assert property (@(posedge clock_i) disable iff (reset_i)
		result_out_first_oe_o == !frame_n_i) else $error("first pin enable wrong");
	oe_second_a: assert property (@(posedge clock_i) disable iff (reset_i)
		result_out_second_oe_o == !frame_n_i) else $error("second pin enable wrong");
	lead_zero_a: assert property (@(posedge sclk_i) disable iff (frame_n_i)
		fall_cnt_r inside {6'h01, 6'h02} |-> !result_out_first_o && !result_out_second_o)
		else $error("leading bit not zero");
	trail_zero_a: assert property (@(posedge sclk_i) disable iff (frame_n_i)
		fall_cnt_r inside {[6'h0F:6'h12]} |-> !result_out_first_o && !result_out_second_o)
		else $error("trailing bit not zero");
	hold_first_a: assert property (@(posedge clock_i) disable iff (frame_n_i)
		sclk_i && $past(sclk_i) && !$past(frame_n_i) |-> $stable(result_out_first_o))
		else $error("first pin moved while clock high");
	hold_second_a: assert property (@(posedge clock_i) disable iff (frame_n_i)
		sclk_i && $past(sclk_i) && !$past(frame_n_i) |-> $stable(result_out_second_o))
		else $error("second pin moved while clock high");
	pulse_once_a: assert property (@(posedge clock_i) disable iff (reset_i)
		sample_pulse_o |=> !sample_pulse_o) else $error("sample pulse too long");
	active_start_a: assert property (@(posedge clock_i) disable iff (reset_i)
		$rose(frame_active_o) |-> !frame_n_i) else $error("frame active without select");
	pulse_idle_a: assert property (@(posedge clock_i) disable iff (reset_i)
		sample_pulse_o |-> frame_n_i && !frame_active_o) else $error("hand-over inside frame");
endmodule : dual_adc_serial_readout_monitor
bind dual_adc_serial_readout dual_adc_serial_readout_monitor mon (.clock_i(clock_i),
	.reset_i(reset_i), .sclk_i(sclk_i), .frame_n_i(frame_n_i),
	.result_out_first_o(result_out_first_o), .result_out_first_oe_o(result_out_first_oe_o),
	.result_out_second_o(result_out_second_o), .result_out_second_oe_o(result_out_second_oe_o),
	.sample_pulse_o(sample_pulse_o), .frame_active_o(frame_active_o));

// ---- bench/host_model.sv ----
// Host model: frames a transfer and runs the serial clock at 48 ns.
// Assumes the bench calls run_frame; the clock stands high between frames.
`timescale 1ns/1ns
module host_model (
	output logic        sclk_o,
	output logic        frame_n_o,
	input  wire logic   data_first_i,
	input  wire logic   data_second_i,
	output logic [31:0] word_first_o,
	output logic [31:0] word_second_o
);
	// A select rise just after start puts the link side into its idle state
	initial begin
		sclk_o = 1'b1;
		frame_n_o = 1'b0;
		#1 frame_n_o = 1'b1;
	end
	// Select low starts the frame, then n clocks; bits taken on rising edges
	task automatic run_frame(input int n);
		word_first_o = 32'h0;
		word_second_o = 32'h0;
		#13 frame_n_o = 1'b0;
		repeat (n) begin
			#24 sclk_o = 1'b0;
			#24 sclk_o = 1'b1;
			word_first_o = {word_first_o[30:0], data_first_i};
			word_second_o = {word_second_o[30:0], data_second_i};
		end
		#24 frame_n_o = 1'b1;
	endtask : run_frame
endmodule : host_model

// ---- bench/dual_adc_serial_readout_tb.sv ----
// Bench for the dual converter serial readout.
// Assumes the host model frames transfers; comparators and selects come from here.
`timescale 1ns/1ns
module dual_adc_serial_readout_tb;
	import dual_adc_pkg::*;
	logic clock_i, reset_i, sclk, frame_n, cfg, rng, cmp_a, cmp_b, d_a, d_b, oe_a, oe_b;
	logic pin_a, pin_b, pulse, active;
	logic [2:0] chan;
	logic [31:0] wa, wb;
	logic [11:0] code_a, code_b, trial_a, trial_b;
	sample_cfg_t scfg;
	result_pair_t lres;
	int error_cnt = 0;
	int num_checks = 0;
	int pulse_cnt = 0;
	// Released pins show the inverse of the cleared output bit, a one, so a late sample shows
	assign pin_a = oe_a ? d_a : ~d_a;
	assign pin_b = oe_b ? d_b : ~d_b;
	host_model host (.sclk_o(sclk), .frame_n_o(frame_n), .data_first_i(pin_a),
		.data_second_i(pin_b), .word_first_o(wa), .word_second_o(wb));
	dual_adc_serial_readout dut (.clock_i(clock_i), .reset_i(reset_i), .sclk_i(sclk),
		.frame_n_i(frame_n), .channel_pair_select_i(chan), .input_config_select_i(cfg),
		.range_select_i(rng), .cmp_first_i(cmp_a), .cmp_second_i(cmp_b),
		.trial_first_o(trial_a), .trial_second_o(trial_b), .result_out_first_o(d_a),
		.result_out_first_oe_o(oe_a), .result_out_second_o(d_b),
		.result_out_second_oe_o(oe_b), .sample_cfg_o(scfg), .sample_pulse_o(pulse),
		.last_result_o(lres), .frame_active_o(active));
	// Comparators: keep the trial bit while the input code is not below it
	always @(posedge clock_i) begin
		cmp_a <= code_a >= trial_a;
		cmp_b <= code_b >= trial_b;
	end
	// Hand-over pulses seen so far
	always @(posedge clock_i) begin
		if (pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
	end
	task chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task finish_test;
		$display("errors %0d checks %0d", error_cnt, num_checks);
		if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	// Selects and input codes settle well before the frame starts
	task setup(input logic [2:0] c, input logic s, r, input logic [11:0] a, b);
		@(posedge clock_i);
		chan <= c;
		cfg <= s;
		rng <= r;
		code_a <= a;
		code_b <= b;
		repeat (4) @(posedge clock_i);
	endtask : setup
	// Full chained frame, one distinct code per converter
	task chained_frame;
		setup(3'h5, 1'b1, 1'b1, 12'hA53, 12'h3C6);
		fork
			host.run_frame(32);
			begin
				repeat (12) @(posedge clock_i);
				chk(active === 1'b1, "frame not seen active");
			end
		join
		chk(wa[31:30] === 2'h0 && wb[31:30] === 2'h0, "leading zeros");
		chk(wa[17:14] === 4'h0 && wb[17:14] === 4'h0, "trailing zeros");
		chk(wa[13:2] === 12'h3C6 && wb[13:2] === 12'hA53, "chained word");
		chk(wa[29:18] === 12'hA53 && wb[29:18] === 12'h3C6, "pin words");
		repeat (8) @(posedge clock_i);
		chk(trial_a === 12'hA53 && trial_b === 12'h3C6, "final trial code");
		chk(scfg === {3'h5, 1'b1, 1'b1}, "config double span");
		chk(oe_a === 1'b0 && oe_b === 1'b0 && active === 1'b0, "pins released");
		chk(lres === {12'hA53, 12'h3C6} && pulse_cnt == 1, "results handed over");
	endtask : chained_frame
	// Short frame with other codes and single span
	task short_frame;
		setup(3'h2, 1'b0, 1'b0, 12'h5AC, 12'hC39);
		host.run_frame(14);
		chk(wa[13:12] === 2'h0 && wb[13:12] === 2'h0, "short leading zeros");
		chk(wa[11:0] === 12'h5AC && wb[11:0] === 12'hC39, "short words");
		repeat (8) @(posedge clock_i);
		chk(scfg === {3'h2, 1'b0, 1'b0}, "config single span");
		chk(lres === {12'h5AC, 12'hC39} && pulse_cnt == 2, "short hand-over");
	endtask : short_frame
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	initial begin
		#300000;
		error_cnt++;
		finish_test;
	end
	initial begin
		reset_i = 1'b1;
		{chan, cfg, rng, code_a, code_b} = 29'h0000000;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		chained_frame;
		short_frame;
		finish_test;
	end
endmodule : dual_adc_serial_readout_tb
